// *** verilog/pmc_pkg.sv ***
// constants, mode codes and counts for the power-mode controller
package pmc_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_ACTIVE     = 4'h0,
    ST_SLEEP      = 4'h1,
    ST_SUBACTIVE  = 4'h2,
    ST_SUBSLEEP   = 4'h3,
    ST_STANDBY    = 4'h4,
    ST_OSC_SETTLE = 4'h5,
    ST_DT_OLD     = 4'h6,
    ST_DT_EXC     = 4'h7,
    ST_RST_HOLD   = 4'h8
  } mode_e;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int CNT_W          = 24;  // settle counter width
  localparam int NUM_MODULES    = 8;   // peripherals with standby bits
  typedef logic [CNT_W-1:0] cnt_t;

  // sleep execution states plus internal processing states
  localparam logic [3:0] OLD_CLK_STATES = 4'h3;
  // exception handling states after a direct transition
  localparam logic [3:0] EXC_STATES     = 4'hE;
  // default oscillator settling wait, in system clock states
  localparam int unsigned SETTLE_BASE   = 8192;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam mode_e      STATE_RST  = ST_ACTIVE;
  localparam logic [2:0] ACT_DIV_RST = 3'h0;
  localparam logic [1:0] SUB_DIV_RST = 2'h0;
  localparam logic [3:0] STEP_RST    = 4'h0;
  localparam logic       PIN_IDLE    = 1'b1;

endpackage : pmc_pkg

// *** verilog/settle_if.sv ***
// handshake between the sequencer and the settle timer
`timescale 1ns/100ps
interface settle_if;
  logic          start;
  pmc_pkg::cnt_t cycles;
  logic          done;
  modport ctrl  (output start, output cycles, input done);
  modport timer (input start, input cycles, output done);
endinterface : settle_if

// *** verilog/settle_timer.sv ***
// oscillator settling down-counter, runs while the cpu clock is stopped
`timescale 1ns/100ps
module settle_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // sequencer side
  settle_if.timer  bus
);

  pmc_pkg::cnt_t cnt_q;
  pmc_pkg::cnt_t cnt_d;

  // load on start, count to zero
  always_comb begin
    cnt_d = cnt_q;
    if (bus.start) begin
      cnt_d = bus.cycles;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - pmc_pkg::cnt_t'(1);
    end
  end

  assign bus.done = (cnt_q == '0) && !bus.start;

  // counter register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : settle_timer

// *** verilog/clk_div_gen.sv ***
// power-of-two divider giving a one-cycle enable every 2**shift ticks
`timescale 1ns/100ps
module clk_div_gen (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // tick in, ratio, tick out
  input  wire logic       tick_in,
  input  wire logic [2:0] shift,
  output logic            tick_out
);

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] limit;

  // wrap the count at the selected ratio
  always_comb begin
    limit = 7'((8'h01 << shift) - 8'h01);
    cnt_d = cnt_q;
    if (tick_in) begin
      cnt_d = (cnt_q >= limit) ? 7'h00 : cnt_q + 7'h01;
    end
  end

  assign tick_out = tick_in && (cnt_q >= limit);

  // divider register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : clk_div_gen

// *** verilog/power_mode_controller.sv ***
// power-mode sequencer: sleep decode, wake-up, dividers, module standby
//
// Notes on behaviour
// - standby: oscillator off, cpu halted, ports high-z
// - standby wake: restart oscillator, settle, then exception
// - masked or disabled interrupt never clears standby/subsleep
// - reset pin low: restart oscillator, settle, await release
// - subsleep: only timer A runs, ports hold state
// - subsleep wake goes active or subactive by flag
// - subactive cpu clock is watch clock /2 /4 /8
// - new divider settings apply only after sleep
// - sleep in subactive decodes any target mode
// - decode: direct flag, standby, subsleep, low-speed bits
// - direct transition switches clock, then direct exception
// - direct interrupt disabled: sleep or subsleep instead
// - direct attempt while masked: unwakeable sleep or subsleep
// - active to subactive: old clock, then subclock exception
// - subactive to active: old clock, settle, new clock
// - per-module standby bit gates that module's clock
`timescale 1ns/100ps
module power_mode_controller #(
  parameter int unsigned settle_base = pmc_pkg::SETTLE_BASE
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // cpu and interrupt controller
  input  wire logic       sleep_exec,
  input  wire logic       int_mask,
  input  wire logic       irq_request,
  input  wire logic       irq_enabled,
  input  wire logic       direct_int_enable,
  // system control one bits
  input  wire logic       standby_select,
  input  wire logic [2:0] wakeup_wait_select,
  // system control two bits
  input  wire logic       subsleep_select,
  input  wire logic       low_speed_on_flag,
  input  wire logic       direct_transition_flag,
  input  wire logic       subactive_divider_hi,
  input  wire logic       subactive_divider_lo,
  input  wire logic       active_divider_b2,
  input  wire logic       active_divider_b1,
  input  wire logic       active_divider_b0,
  // module standby bits
  input  wire logic [7:0] module_standby,
  // pins
  input  wire logic       chip_init_pin_n,
  input  wire logic       subclock_xtal_in,
  output logic            subclock_xtal_out,
  // mode status
  output logic [3:0]      mode_state,
  output logic            sys_osc_run,
  output logic            io_hiz,
  output logic            io_hold,
  output logic            wake_locked,
  // clock enables
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            timer_a_clk_en,
  output logic [7:0]      module_clk_en,
  // exception starts
  output logic            int_exc_start,
  output logic            direct_exc_start,
  output logic            reset_exc_start
);

  // ----------------------------------------------------------------
  // pin synchronisers and watch tick
  // ----------------------------------------------------------------
  logic pin_s1_q, pin_s2_q, x_s1_q, x_s2_q, x_s3_q, xout_q;
  logic pin_s1_d, pin_s2_d, x_s1_d, x_s2_d, x_s3_d, xout_d;
  logic watch_tick;

  // two flops per pin, third flop for the edge
  always_comb begin
    pin_s1_d = chip_init_pin_n;
    pin_s2_d = pin_s1_q;
    x_s1_d   = subclock_xtal_in;
    x_s2_d   = x_s1_q;
    x_s3_d   = x_s2_q;
    xout_d   = !x_s2_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_s1_q <= pmc_pkg::PIN_IDLE;
      pin_s2_q <= pmc_pkg::PIN_IDLE;
      x_s1_q   <= 1'b0;
      x_s2_q   <= 1'b0;
      x_s3_q   <= 1'b0;
      xout_q   <= 1'b0;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      x_s1_q   <= x_s1_d;
      x_s2_q   <= x_s2_d;
      x_s3_q   <= x_s3_d;
      xout_q   <= xout_d;
    end
  end

  // watch edge seen on the always-on clock
  assign watch_tick        = x_s2_q && !x_s3_q;
  assign subclock_xtal_out = xout_q;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  pmc_pkg::mode_e state_q, state_d;
  logic [3:0]     cnt_q, cnt_d;
  logic [2:0]     eff_ma_q, eff_ma_d;
  logic [1:0]     eff_sa_q, eff_sa_d;
  logic clk_sub_q, clk_sub_d, osc_q, osc_d, tgt_sub_q, tgt_sub_d;
  logic dt_q, dt_d, no_wake_q, no_wake_d;
  logic int_exc_q, int_exc_d, dt_exc_q, dt_exc_d;
  logic rst_exc_q, rst_exc_d, hiz_q, hiz_d, hold_q, hold_d;
  logic wake, act_tick, sub_tick, cpu_tick, run_state;
  logic settle_start;
  logic [2:0] sub_shift;
  pmc_pkg::cnt_t settle_len;
  pmc_pkg::cnt_t settle_wait;

  settle_if st_bus ();

  settle_timer u_settle (
    .ref_clk (ref_clk),
    .reset   (reset),
    .bus     (st_bus)
  );

  // subactive ratio: 00 -> /2, 01 -> /4, 1x -> /8
  assign sub_shift = eff_sa_q[1] ? 3'h3 : (eff_sa_q[0] ? 3'h2 : 3'h1);

  clk_div_gen u_act_div (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .tick_in  (osc_q),
    .shift    (eff_ma_q),
    .tick_out (act_tick)
  );

  clk_div_gen u_sub_div (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .tick_in  (watch_tick),
    .shift    (sub_shift),
    .tick_out (sub_tick)
  );

  // masked, disabled or locked requests never wake
  assign wake        = irq_request && irq_enabled && !int_mask && !no_wake_q;
  assign cpu_tick    = clk_sub_q ? sub_tick : act_tick;
  assign settle_wait = pmc_pkg::cnt_t'(settle_base) << wakeup_wait_select;
  assign run_state   = (state_q == pmc_pkg::ST_ACTIVE) ||
                       (state_q == pmc_pkg::ST_SUBACTIVE);
  assign st_bus.start  = settle_start;
  assign st_bus.cycles = settle_len;

  // next-state decode
  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    clk_sub_d    = clk_sub_q;
    osc_d        = osc_q;
    tgt_sub_d    = tgt_sub_q;
    dt_d         = dt_q;
    no_wake_d    = no_wake_q;
    eff_ma_d     = eff_ma_q;
    eff_sa_d     = eff_sa_q;
    int_exc_d    = 1'b0;
    dt_exc_d     = 1'b0;
    rst_exc_d    = 1'b0;
    settle_start = 1'b0;
    settle_len   = settle_wait;
    if (!pin_s2_q) begin
      // restart oscillator and time its settling
      state_d    = pmc_pkg::ST_RST_HOLD;
      osc_d      = 1'b1;
      clk_sub_d  = 1'b0;
      dt_d       = 1'b0;
      no_wake_d  = 1'b0;
      eff_ma_d   = pmc_pkg::ACT_DIV_RST;
      eff_sa_d   = pmc_pkg::SUB_DIV_RST;
      settle_len = pmc_pkg::cnt_t'(settle_base);
      settle_start = (state_q != pmc_pkg::ST_RST_HOLD);
    end else begin
      case (state_q)
        pmc_pkg::ST_ACTIVE, pmc_pkg::ST_SUBACTIVE: begin
          if (sleep_exec) begin
            eff_ma_d = {active_divider_b2, active_divider_b1,
                        active_divider_b0};
            eff_sa_d = {subactive_divider_hi, subactive_divider_lo};
            if (direct_transition_flag) begin
              if (!direct_int_enable || int_mask) begin
                // fall back, lock wake when masked
                state_d   = subsleep_select ? pmc_pkg::ST_SUBSLEEP :
                                              pmc_pkg::ST_SLEEP;
                osc_d     = osc_q && !subsleep_select;
                no_wake_d = int_mask;
              end else begin
                state_d   = pmc_pkg::ST_DT_OLD;
                cnt_d     = pmc_pkg::STEP_RST;
                tgt_sub_d = low_speed_on_flag;
              end
            end else if (standby_select) begin
              state_d = pmc_pkg::ST_STANDBY;
              osc_d   = 1'b0;
            end else if (subsleep_select) begin
              state_d = pmc_pkg::ST_SUBSLEEP;
              osc_d   = 1'b0;
            end else begin
              state_d = pmc_pkg::ST_SLEEP;
            end
          end
        end
        pmc_pkg::ST_SLEEP, pmc_pkg::ST_SUBSLEEP,
        pmc_pkg::ST_STANDBY: begin
          if (wake) begin
            if (state_q == pmc_pkg::ST_STANDBY || !low_speed_on_flag) begin
              if (osc_q) begin
                state_d   = pmc_pkg::ST_ACTIVE;
                clk_sub_d = 1'b0;
                int_exc_d = 1'b1;
              end else begin
                // restart and wait the selected time
                state_d      = pmc_pkg::ST_OSC_SETTLE;
                osc_d        = 1'b1;
                dt_d         = 1'b0;
                settle_start = 1'b1;
              end
            end else begin
              state_d   = pmc_pkg::ST_SUBACTIVE;
              clk_sub_d = 1'b1;
              osc_d     = 1'b0;
              int_exc_d = 1'b1;
            end
          end
        end
        pmc_pkg::ST_OSC_SETTLE: begin
          if (st_bus.done) begin
            clk_sub_d = 1'b0;
            if (dt_q) begin
              // exception runs on the new system clock
              state_d  = pmc_pkg::ST_DT_EXC;
              cnt_d    = pmc_pkg::STEP_RST;
              dt_exc_d = 1'b1;
            end else begin
              state_d   = pmc_pkg::ST_ACTIVE;
              int_exc_d = 1'b1;
            end
          end
        end
        pmc_pkg::ST_DT_OLD: begin
          // sleep and internal states on old clock
          if (cpu_tick) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == pmc_pkg::OLD_CLK_STATES - 4'h1) begin
              cnt_d = pmc_pkg::STEP_RST;
              if (tgt_sub_q) begin
                state_d   = pmc_pkg::ST_DT_EXC;
                clk_sub_d = 1'b1;
                osc_d     = 1'b0;
                dt_exc_d  = 1'b1;
              end else if (!osc_q) begin
                state_d      = pmc_pkg::ST_OSC_SETTLE;
                osc_d        = 1'b1;
                dt_d         = 1'b1;
                settle_start = 1'b1;
              end else begin
                state_d   = pmc_pkg::ST_DT_EXC;
                clk_sub_d = 1'b0;
                dt_exc_d  = 1'b1;
              end
            end
          end
        end
        pmc_pkg::ST_DT_EXC: begin
          // exception states counted on the new clock
          if (cpu_tick) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == pmc_pkg::EXC_STATES - 4'h1) begin
              cnt_d   = pmc_pkg::STEP_RST;
              state_d = tgt_sub_q ? pmc_pkg::ST_SUBACTIVE :
                                    pmc_pkg::ST_ACTIVE;
            end
          end
        end
        pmc_pkg::ST_RST_HOLD: begin
          // pin already released here, wait for stable clock
          if (st_bus.done) begin
            state_d   = pmc_pkg::ST_ACTIVE;
            rst_exc_d = 1'b1;
          end
        end
        default: begin
          state_d = pmc_pkg::ST_ACTIVE;
        end
      endcase
    end
    // port behaviour follows the next mode
    hiz_d  = (state_d == pmc_pkg::ST_STANDBY);
    hold_d = (state_d == pmc_pkg::ST_SLEEP) ||
             (state_d == pmc_pkg::ST_SUBSLEEP);
  end

  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q   <= pmc_pkg::STATE_RST;
      cnt_q     <= pmc_pkg::STEP_RST;
      eff_ma_q  <= pmc_pkg::ACT_DIV_RST;
      eff_sa_q  <= pmc_pkg::SUB_DIV_RST;
      clk_sub_q <= 1'b0;
      osc_q     <= 1'b1;
      tgt_sub_q <= 1'b0;
      dt_q      <= 1'b0;
      no_wake_q <= 1'b0;
      int_exc_q <= 1'b0;
      dt_exc_q  <= 1'b0;
      rst_exc_q <= 1'b0;
      hiz_q     <= 1'b0;
      hold_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      eff_ma_q  <= eff_ma_d;
      eff_sa_q  <= eff_sa_d;
      clk_sub_q <= clk_sub_d;
      osc_q     <= osc_d;
      tgt_sub_q <= tgt_sub_d;
      dt_q      <= dt_d;
      no_wake_q <= no_wake_d;
      int_exc_q <= int_exc_d;
      dt_exc_q  <= dt_exc_d;
      rst_exc_q <= rst_exc_d;
      hiz_q     <= hiz_d;
      hold_q    <= hold_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs and clock gating
  // ----------------------------------------------------------------
  assign mode_state       = state_q;
  assign sys_osc_run      = osc_q;
  assign io_hiz           = hiz_q;
  assign io_hold          = hold_q;
  assign wake_locked      = no_wake_q;
  assign int_exc_start    = int_exc_q;
  assign direct_exc_start = dt_exc_q;
  assign reset_exc_start  = rst_exc_q;
  assign timer_a_clk_en   = watch_tick;
  assign cpu_clk_en       = cpu_tick && (run_state ||
                            state_q == pmc_pkg::ST_DT_OLD ||
                            state_q == pmc_pkg::ST_DT_EXC);
  // peripherals stopped in subsleep and standby
  assign periph_clk_en    = cpu_tick && (run_state ||
                            state_q == pmc_pkg::ST_SLEEP);

  for (genvar i = 0; i < pmc_pkg::NUM_MODULES; i++) begin : g_mstby
    assign module_clk_en[i] = periph_clk_en && !module_standby[i];
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  standby_hiz_a: assert property (
    state_q == pmc_pkg::ST_STANDBY && $past(state_q) ==
      pmc_pkg::ST_STANDBY |-> io_hiz && !sys_osc_run && !cpu_clk_en)
    else $error("standby outputs wrong");
  wake_settle_a: assert property (
    state_q == pmc_pkg::ST_STANDBY && wake && pin_s2_q && !osc_q
      |=> state_q == pmc_pkg::ST_OSC_SETTLE ##1 !st_bus.done)
    else $error("standby wake did not settle");
  masked_stay_a: assert property (
    (state_q == pmc_pkg::ST_STANDBY || state_q == pmc_pkg::ST_SUBSLEEP)
      && int_mask && pin_s2_q |=> $stable(state_q))
    else $error("masked interrupt left low-power mode");
  reset_hold_a: assert property (
    !pin_s2_q |=> state_q == pmc_pkg::ST_RST_HOLD && sys_osc_run
      && !reset_exc_start)
    else $error("reset pin low not held");
  subsleep_gate_a: assert property (
    state_q == pmc_pkg::ST_SUBSLEEP |-> io_hold && !cpu_clk_en
      && module_clk_en == 8'h00)
    else $error("subsleep clocks not stopped");
  subsleep_wake_a: assert property (
    state_q == pmc_pkg::ST_SUBSLEEP && wake && pin_s2_q
      && low_speed_on_flag |=> state_q == pmc_pkg::ST_SUBACTIVE
      && int_exc_start)
    else $error("subsleep wake target wrong");
  sub_clock_a: assert property (
    state_q == pmc_pkg::ST_SUBACTIVE && cpu_clk_en |-> watch_tick)
    else $error("subactive clock not from watch");
  div_latch_a: assert property (
    run_state && sleep_exec && pin_s2_q |=>
      eff_sa_q == $past({subactive_divider_hi, subactive_divider_lo}))
    else $error("divider not latched at sleep");
  standby_decode_a: assert property (
    run_state && sleep_exec && pin_s2_q && !direct_transition_flag
      && standby_select |=> state_q == pmc_pkg::ST_STANDBY)
    else $error("standby decode wrong");
  direct_start_a: assert property (
    run_state && sleep_exec && pin_s2_q && direct_transition_flag
      && direct_int_enable && !int_mask |=> state_q == pmc_pkg::ST_DT_OLD)
    else $error("direct transition not started");
  masked_lock_a: assert property (
    run_state && sleep_exec && pin_s2_q && direct_transition_flag
      && int_mask |=> wake_locked && !run_state)
    else $error("masked direct attempt not locked");
  exc_count_a: assert property (
    state_q == pmc_pkg::ST_DT_EXC |-> cnt_q < pmc_pkg::EXC_STATES)
    else $error("exception count overran");
  mstby_gate_a: assert property (
    module_standby[0] |-> !module_clk_en[0])
    else $error("standby module still clocked");

  standby_exit_c: cover property (
    state_q == pmc_pkg::ST_OSC_SETTLE ##[1:100] int_exc_start);
  direct_exc_c: cover property ($rose(direct_exc_start));
  reset_exc_c: cover property ($rose(reset_exc_start));

endmodule : power_mode_controller

// *** dv/cpu_irq_model.sv ***
// cpu, interrupt controller and reset driver model
`timescale 1ns/100ps
module cpu_irq_model (
  // clock
  input  wire logic ref_clk,
  // bench requests
  input  wire logic want_irq,
  input  wire logic want_rst,
  // controller status
  input  wire logic exc_start,
  input  wire logic osc_run,
  // to the controller
  output logic      irq_request,
  output logic      chip_init_pin_n
);
  int stable_n;

  // idle levels at time zero
  initial begin
    irq_request = 1'b0;
    chip_init_pin_n = 1'b1;
    stable_n = 0;
  end

  // request stands until an exception takes it
  // sampled on the rising edge, clear of the bench's falling-edge changes
  always @(posedge ref_clk) begin
    if (want_irq) irq_request <= 1'b1;
    else if (exc_start) irq_request <= 1'b0;
    stable_n <= (osc_run && !want_rst) ? stable_n + 1 : 0;
    if (want_rst) chip_init_pin_n <= 1'b0;
    else if (stable_n > 40) chip_init_pin_n <= 1'b1;
  end
endmodule : cpu_irq_model

// *** dv/power_mode_controller_test.sv ***
// self-checking bench for the power-mode controller
`timescale 1ns/100ps
module power_mode_controller_test;
  logic       ref_clk, reset, sleep_exec, int_mask, irq_enabled;
  logic       direct_int_enable, standby_select, subsleep_select;
  logic       low_speed_on_flag, direct_transition_flag, want_irq;
  logic       subactive_divider_hi, subactive_divider_lo, want_rst;
  logic       subclock_xtal_in, irq_request, chip_init_pin_n;
  logic       sys_osc_run, io_hiz, io_hold, wake_locked, cpu_clk_en;
  logic       periph_clk_en, timer_a_clk_en, int_exc_start;
  logic       direct_exc_start, reset_exc_start;
  logic       subclock_xtal_out, xo_prev;
  logic       active_divider_b2, active_divider_b1, active_divider_b0;
  logic [2:0] wakeup_wait_select;
  logic [3:0] mode_state;
  logic [7:0] module_standby, module_clk_en, or_en;
  int         bad_count, n_checks, waited, n_int, n_dir, n_rst;
  int         c_cpu, c_tmr, c_xo, d, diff;

  power_mode_controller #(.settle_base(16)) u_power_mode_controller (
    .ref_clk, .reset, .sleep_exec, .int_mask, .irq_request,
    .irq_enabled, .direct_int_enable, .standby_select,
    .wakeup_wait_select, .subsleep_select, .low_speed_on_flag,
    .direct_transition_flag, .subactive_divider_hi,
    .subactive_divider_lo, .active_divider_b2, .active_divider_b1,
    .active_divider_b0, .module_standby, .chip_init_pin_n,
    .subclock_xtal_in, .subclock_xtal_out, .mode_state,
    .sys_osc_run, .io_hiz,
    .io_hold, .wake_locked, .cpu_clk_en, .periph_clk_en,
    .timer_a_clk_en, .module_clk_en, .int_exc_start,
    .direct_exc_start, .reset_exc_start
  );

  cpu_irq_model u_cpu_irq_model (
    .ref_clk, .want_irq, .want_rst, .irq_request, .chip_init_pin_n,
    .exc_start(int_exc_start | reset_exc_start), .osc_run(sys_osc_run)
  );

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // subclock always fitted, rising edge every 8 cycles
  always begin
    repeat (4) @(negedge ref_clk);
    subclock_xtal_in = ~subclock_xtal_in;
  end

  // exception pulse tallies
  always @(posedge ref_clk) begin
    n_int <= n_int + int_exc_start;
    n_dir <= n_dir + direct_exc_start;
    n_rst <= n_rst + reset_exc_start;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // bounded wait for a mode code
  task automatic wait_mode(input logic [3:0] m);
    for (waited = 0; waited < 4000; waited++) begin
      if (mode_state === m) break;
      @(negedge ref_clk);
    end
    chk(mode_state, m);
    // a used-up bound is a mismatch of its own
    if (waited == 4000) begin
      bad_count++;
      wrap_up();
    end
  endtask : wait_mode

  // bits are direct, standby, subsleep, low speed
  task automatic sleep_go(input logic [3:0] b);
    {direct_transition_flag, standby_select} = b[3:2];
    {subsleep_select, low_speed_on_flag} = b[1:0];
    sleep_exec = 1'b1;
    @(negedge ref_clk);
    sleep_exec = 1'b0;
    @(negedge ref_clk);
  endtask : sleep_go

  task automatic irq_go;
    want_irq = 1'b1;
    @(negedge ref_clk);
    want_irq = 1'b0;
  endtask : irq_go

  // tally clock enables over n cycles
  task automatic count(input int n);
    {c_cpu, c_tmr, c_xo, or_en} = '0;
    xo_prev = subclock_xtal_out;
    repeat (n) begin
      @(negedge ref_clk);
      c_cpu += cpu_clk_en;
      c_tmr += timer_a_clk_en;
      or_en |= module_clk_en;
      c_xo += (subclock_xtal_out && !xo_prev);
      xo_prev = subclock_xtal_out;
    end
  endtask : count

  initial begin
    {reset, sleep_exec, int_mask, want_irq, want_rst} = 5'h10;
    {subclock_xtal_in, subactive_divider_hi} = 2'h0;
    {subactive_divider_lo, direct_int_enable, irq_enabled} = 3'h3;
    {standby_select, subsleep_select} = 2'h0;
    {low_speed_on_flag, direct_transition_flag} = 2'h0;
    {wakeup_wait_select, module_standby} = '0;
    {active_divider_b2, active_divider_b1, active_divider_b0} = 3'h0;
    {bad_count, n_checks, n_int, n_dir, n_rst} = '0;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    // standby entry, refused and accepted wake
    wakeup_wait_select = 3'h1;
    sleep_go(4'h4);
    wait_mode(4'h4);
    chk(io_hiz, 8'h01);
    chk(sys_osc_run, 8'h00);
    int_mask = 1'b1;
    irq_go();
    repeat (60) @(negedge ref_clk);
    chk(mode_state, 8'h04);
    {int_mask, irq_enabled} = 2'h0;
    repeat (10) @(negedge ref_clk);
    chk(mode_state, 8'h04);
    irq_enabled = 1'b1;
    wait_mode(4'h0);
    chk(waited >= 32, 8'h01);
    // tallies see a pulse one edge after the mode change
    @(negedge ref_clk);
    chk(n_int, 8'h01);
    // subsleep with only timer a running, wake to subactive
    sleep_go(4'h3);
    wait_mode(4'h3);
    chk(io_hold, 8'h01);
    count(64);
    chk(c_cpu, 8'h00);
    chk(c_tmr, 8'h08);
    chk(c_xo, 8'h08);
    irq_go();
    wait_mode(4'h2);
    @(negedge ref_clk);
    chk(n_int, 8'h02);
    // subactive dividers latched at sleep, a change after sleep keeps the rate
    for (d = 0; d < 3; d++) begin
      {subactive_divider_hi, subactive_divider_lo} = d[1:0];
      sleep_go(4'h9);
      wait_mode(4'h7);
      wait_mode(4'h2);
      {subactive_divider_hi, subactive_divider_lo} = ~d[1:0];
      count(640);
      diff = c_cpu * (2 << d) - c_tmr;
      chk(diff <= (2 << d) && diff >= -(2 << d), 8'h01);
      chk(n_dir, 8'(d + 1));
    end
    // sleep from subactive, wake to active through settling
    sleep_go(4'h0);
    wait_mode(4'h1);
    irq_go();
    wait_mode(4'h5);
    wait_mode(4'h0);
    // direct transitions both ways
    sleep_go(4'h9);
    wait_mode(4'h6);
    wait_mode(4'h7);
    wait_mode(4'h2);
    sleep_go(4'h8);
    wait_mode(4'h6);
    wait_mode(4'h5);
    wait_mode(4'h7);
    wait_mode(4'h0);
    chk(n_dir, 8'h05);
    // direct interrupt disabled gives sleep, active /4 latched there
    direct_int_enable = 1'b0;
    {active_divider_b2, active_divider_b1, active_divider_b0} = 3'h2;
    sleep_go(4'h8);
    wait_mode(4'h1);
    irq_go();
    wait_mode(4'h0);
    {active_divider_b2, active_divider_b1, active_divider_b0} = 3'h0;
    count(64);
    chk(c_cpu, 8'h10);
    // masked direct attempt locks, only reset pin frees
    {int_mask, direct_int_enable} = 2'h3;
    sleep_go(4'hA);
    wait_mode(4'h3);
    chk(wake_locked, 8'h01);
    int_mask = 1'b0;
    irq_go();
    repeat (40) @(negedge ref_clk);
    chk(mode_state, 8'h03);
    want_rst = 1'b1;
    @(negedge ref_clk);
    want_rst = 1'b0;
    wait_mode(4'h8);
    wait_mode(4'h0);
    @(negedge ref_clk);
    chk(n_rst, 8'h01);
    // module standby gating
    module_standby = 8'hA5;
    count(8);
    chk(or_en, 8'h5A);
    module_standby = 8'h00;
    count(8);
    chk(or_en, 8'hFF);
    wrap_up();
  end
endmodule : power_mode_controller_test
